// file: design/svm_pkg.sv
package svm_pkg;

  // register map (word indices on the plain register port)
  localparam logic [3:0] ADDR_CTRL      = 4'h0;
  localparam logic [3:0] ADDR_IRQ_STAT  = 4'h1;
  localparam logic [3:0] ADDR_IRQ_MASK  = 4'h2;
  localparam logic [3:0] ADDR_IRQ_REQ   = 4'h3;

  // control register fields
  localparam int         BIT_LOW_FLAG   = 5;
  localparam int         BIT_MON_EN     = 4;
  localparam int         BIT_BG_BUF_EN  = 3;
  localparam int         THR_MSB        = 2;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] CTRL_WR_MASK   = 8'h1F;

  // status/mask layout
  localparam int         EV_LOW_SET     = 0;
  localparam int         EV_LOW_CLR     = 1;
  localparam int         EV_IRQ_REQ     = 2;
  localparam int         NUM_EV         = 3;

  // threshold table in millivolts, codes 000..111
  localparam logic [15:0] THR_MV [8] = '{16'h07D0, 16'h0898, 16'h0960, 16'h0A8C,
                                         16'h0BB8, 16'h0CE4, 16'h0E10, 16'h0FA0};

  // timing
  localparam int CLK_MHZ        = 125;
  localparam int IRQ_DELAY_US   = 15;
  localparam int IRQ_DELAY_CYC  = IRQ_DELAY_US * CLK_MHZ;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

endpackage : svm_pkg

// file: design/svm_delay.sv
`timescale 1ns/1ps
`default_nettype none
// counts consecutive cycles of a level; fires once when the count completes
module svm_delay #(
  parameter int CYCLES = 16
) (
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_level,
  output logic      o_done
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          done_ff;
  logic          nxt_done;

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_done = 1'b0;
    if (!i_level) begin
      nxt_cnt = '0;
    end else if (cnt_ff < CW'(CYCLES)) begin
      nxt_cnt  = cnt_ff + 1'b1;
      nxt_done = (cnt_ff == CW'(CYCLES - 1));
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign o_done = done_ff;
endmodule : svm_delay
`default_nettype wire

// file: design/supply_voltage_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module supply_voltage_monitor
  import svm_pkg::*;
#(
  parameter int IRQ_DELAY = IRQ_DELAY_CYC
) (
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RESET_N,
  // register port
  input  wire logic [3:0]  I_ADDR,
  input  wire logic [7:0]  I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic [7:0]       O_RDATA,
  // analogue side and power modes
  input  wire logic        I_CMP_BELOW,
  input  wire logic        I_LVR_ENABLE,
  input  wire logic        I_SLEEP,
  input  wire logic        I_IDLE,
  output logic             O_MONITOR_ON,
  output logic             O_BANDGAP_ON,
  output logic [2:0]       O_THRESHOLD_SELECT,
  output logic [15:0]      O_THRESHOLD_MV,
  // events
  output logic             O_WAKE,
  output logic             O_IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  reg_req_s req;
  assign req = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};

  // comparator is analogue, so it crosses into the clock domain first
  logic cmp_s1_ff;
  logic cmp_s2_ff;
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
    end else begin
      cmp_s1_ff <= I_CMP_BELOW;
      cmp_s2_ff <= cmp_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [4:0] ctrl_ff;
  logic [4:0] nxt_ctrl;
  logic       low_ff;
  logic       nxt_low;
  logic       req_ff;
  logic       nxt_req;
  logic [NUM_EV-1:0] stat_ff;
  logic [NUM_EV-1:0] nxt_stat;
  logic [NUM_EV-1:0] mask_ff;
  logic [NUM_EV-1:0] nxt_mask;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic       mon_active;
  logic       delay_done;
  logic [NUM_EV-1:0] ev;

  assign mon_active = ctrl_ff[BIT_MON_EN] & ~I_SLEEP;

  svm_delay #(.CYCLES(IRQ_DELAY)) u_delay (
    .i_clk     (I_CLK),
    .i_reset_n (I_RESET_N),
    .i_level   (low_ff),
    .o_done    (delay_done)
  );

  assign ev[EV_LOW_SET] = nxt_low & ~low_ff;
  assign ev[EV_LOW_CLR] = ~nxt_low & low_ff;
  assign ev[EV_IRQ_REQ] = delay_done & ~req_ff;

  always_comb begin
    nxt_ctrl  = ctrl_ff;
    nxt_mask  = mask_ff;
    nxt_req   = req_ff;
    nxt_stat  = stat_ff;
    nxt_rdata = 8'h00;
    nxt_low   = mon_active & cmp_s2_ff;
    if (req.wr) begin
      case (req.addr)
        ADDR_CTRL:     nxt_ctrl = req.wdata[4:0] & CTRL_WR_MASK[4:0];
        ADDR_IRQ_MASK: nxt_mask = req.wdata[NUM_EV-1:0];
        ADDR_IRQ_REQ:  nxt_req  = req.wdata[0];
        default:       nxt_ctrl = ctrl_ff;
      endcase
    end
    if (req.rd) begin
      case (req.addr)
        ADDR_CTRL:     nxt_rdata = {2'b00, low_ff, ctrl_ff};
        ADDR_IRQ_STAT: nxt_rdata = {{(8-NUM_EV){1'b0}}, stat_ff};
        ADDR_IRQ_MASK: nxt_rdata = {{(8-NUM_EV){1'b0}}, mask_ff};
        ADDR_IRQ_REQ:  nxt_rdata = {7'h00, req_ff};
        default:       nxt_rdata = 8'h00;
      endcase
      if (req.addr == ADDR_IRQ_STAT) begin
        nxt_stat = '0;
      end
    end
    // hardware set beats the software clear in the same cycle
    if (delay_done) begin
      nxt_req = 1'b1;
    end
    nxt_stat = nxt_stat | ev;
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ctrl_ff  <= CTRL_RESET[4:0];
      low_ff   <= 1'b0;
      req_ff   <= 1'b0;
      stat_ff  <= '0;
      mask_ff  <= '0;
      rdata_ff <= 8'h00;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      low_ff   <= nxt_low;
      req_ff   <= nxt_req;
      stat_ff  <= nxt_stat;
      mask_ff  <= nxt_mask;
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign O_RDATA            = rdata_ff;
  assign O_MONITOR_ON       = mon_active;
  assign O_BANDGAP_ON       = mon_active | I_LVR_ENABLE | ctrl_ff[BIT_BG_BUF_EN];
  assign O_THRESHOLD_SELECT = ctrl_ff[THR_MSB:0];
  assign O_THRESHOLD_MV     = THR_MV[ctrl_ff[THR_MSB:0]];
  // wake is a level: a request already high before idle wakes at once, so software can pre-set it
  assign O_WAKE             = req_ff & I_IDLE;
  assign O_IRQ              = |(stat_ff & mask_ff);

  ////////////////////////////////////////////////////////////////////////////
  property p_thr_table;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      (ctrl_ff[2:0] == 3'h3) |-> (O_THRESHOLD_MV == 16'h0A8C);
  endproperty
  a_thr_table: assert property (p_thr_table) else $error("threshold decode wrong");

  property p_flag_read;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      (req.rd && req.addr == ADDR_CTRL) |=> (O_RDATA[5] == $past(low_ff));
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("flag read mismatch");

  property p_enable_write;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      (req.wr && req.addr == ADDR_CTRL && req.wdata[4] && !I_SLEEP) |=> ##0 (I_SLEEP || O_MONITOR_ON);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("monitor not enabled");

  property p_bandgap;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      (O_MONITOR_ON || I_LVR_ENABLE || ctrl_ff[3]) == O_BANDGAP_ON;
  endproperty
  a_bandgap: assert property (p_bandgap) else $error("bandgap enable wrong");

  property p_upper_zero;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      $past(req.rd) |-> (O_RDATA[7:6] == 2'b00);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");

  property p_sleep_off;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      I_SLEEP |-> (!O_MONITOR_ON ##1 !low_ff);
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("monitor on in sleep");

  property p_req_delay;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      $rose(req_ff) && !$past(req.wr) |-> $past(low_ff);
  endproperty
  a_req_delay: assert property (p_req_delay) else $error("request without low flag");

  property p_req_sticky;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      (req_ff && !(req.wr && req.addr == ADDR_IRQ_REQ)) |=> req_ff;
  endproperty
  a_req_sticky: assert property (p_req_sticky) else $error("request dropped");

  property p_wake;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      (req_ff && I_IDLE) |-> O_WAKE;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake from idle");

  ////////////////////////////////////////////////////////////////////////////
  // flag is the synchronised comparator gated by the monitor, no filtering
  property p_flag_follow;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      low_ff == $past(mon_active && cmp_s2_ff);
  endproperty
  a_flag_follow: assert property (p_flag_follow) else $error("flag not following");

  property p_monitor_off;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      !ctrl_ff[BIT_MON_EN] |-> !O_MONITOR_ON;
  endproperty
  a_monitor_off: assert property (p_monitor_off) else $error("monitor on while off");

  // read data must be zero outside the answer cycle
  property p_rdata_idle;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      !$past(req.rd) |-> (O_RDATA == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  property p_ctrl_write;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      (req.wr && req.addr == ADDR_CTRL) |=> (O_THRESHOLD_SELECT == $past(req.wdata[2:0]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("select not written");

  property p_req_set;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      delay_done |=> req_ff;
  endproperty
  a_req_set: assert property (p_req_set) else $error("request not set");

  // the delay only completes on a flag that was high up to its last cycle
  property p_req_needs_low;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      delay_done |-> $past(low_ff);
  endproperty
  a_req_needs_low: assert property (p_req_needs_low) else $error("delay done without flag");

  property p_done_pulse;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      delay_done |=> !delay_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("delay done repeated");

  // status read leaves the register zero only when no event lands in the same cycle
  property p_stat_clear;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      (req.rd && req.addr == ADDR_IRQ_STAT && ev == '0) |=> (stat_ff == '0);
  endproperty
  a_stat_clear: assert property (p_stat_clear) else $error("status not cleared");

  property p_stat_sticky;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      (stat_ff[EV_LOW_SET] && !(req.rd && req.addr == ADDR_IRQ_STAT)) |=> stat_ff[EV_LOW_SET];
  endproperty
  a_stat_sticky: assert property (p_stat_sticky) else $error("status bit dropped");

  property p_bandgap_lvr;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      I_LVR_ENABLE |-> O_BANDGAP_ON;
  endproperty
  a_bandgap_lvr: assert property (p_bandgap_lvr) else $error("bandgap off with reset on");

  property p_thr_range;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      (O_THRESHOLD_MV >= 16'h07D0) && (O_THRESHOLD_MV <= 16'h0FA0);
  endproperty
  a_thr_range: assert property (p_thr_range) else $error("threshold out of range");

  // wake must not appear without a pending request
  property p_wake_only;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      O_WAKE |-> (req_ff && I_IDLE);
  endproperty
  a_wake_only: assert property (p_wake_only) else $error("spurious wake");

  ////////////////////////////////////////////////////////////////////////////
  // main scenarios the bench is expected to reach
  c_low:   cover property (@(posedge I_CLK) disable iff (!I_RESET_N) $rose(low_ff));
  c_req:   cover property (@(posedge I_CLK) disable iff (!I_RESET_N) $rose(req_ff));
  c_irq:   cover property (@(posedge I_CLK) disable iff (!I_RESET_N) $rose(O_IRQ));
  c_sleep: cover property (@(posedge I_CLK) disable iff (!I_RESET_N) ctrl_ff[4] && I_SLEEP);
  c_wake:  cover property (@(posedge I_CLK) disable iff (!I_RESET_N) $rose(O_WAKE));

endmodule : supply_voltage_monitor
`default_nettype wire

// file: verification/supply_voltage_monitor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module supply_voltage_monitor_tb_top import svm_pkg::*;;
  // short request delay keeps the run brief
  localparam int DLY = 8;
  localparam logic [15:0] EXP_MV [8] = '{16'h07D0, 16'h0898, 16'h0960, 16'h0A8C,
                                        16'h0BB8, 16'h0CE4, 16'h0E10, 16'h0FA0};
  logic        I_CLK = 1'b0;
  logic        I_RESET_N, I_WR, I_RD, I_CMP_BELOW, I_LVR_ENABLE, I_SLEEP, I_IDLE;
  logic [3:0]  I_ADDR;
  logic [7:0]  I_WDATA, O_RDATA;
  logic        O_MONITOR_ON, O_BANDGAP_ON, O_WAKE, O_IRQ;
  logic [2:0]  O_THRESHOLD_SELECT;
  logic [15:0] O_THRESHOLD_MV;
  int          n_errors = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          n;

  supply_voltage_monitor #(.IRQ_DELAY(DLY)) supply_voltage_monitor_i (
    .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_CMP_BELOW(I_CMP_BELOW),
    .I_LVR_ENABLE(I_LVR_ENABLE), .I_SLEEP(I_SLEEP), .I_IDLE(I_IDLE),
    .O_MONITOR_ON(O_MONITOR_ON), .O_BANDGAP_ON(O_BANDGAP_ON),
    .O_THRESHOLD_SELECT(O_THRESHOLD_SELECT), .O_THRESHOLD_MV(O_THRESHOLD_MV),
    .O_WAKE(O_WAKE), .O_IRQ(O_IRQ));

  always #4 I_CLK = ~I_CLK;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // each access waits for an edge first, so strobes never change twice in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge I_CLK);
    I_ADDR  <= a;
    I_WDATA <= d;
    I_WR    <= 1'b1;
    @(posedge I_CLK);
    I_WR <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string nm);
    @(posedge I_CLK);
    I_ADDR <= a;
    I_RD   <= 1'b1;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1;
    chk(nm, 16'(exp), 16'(O_RDATA));
  endtask : rd

  always @(posedge I_CLK) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      $display("Error timeout expected done seen hang");
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {I_RESET_N, I_WR, I_RD, I_CMP_BELOW, I_LVR_ENABLE, I_SLEEP, I_IDLE} = '0;
    I_ADDR  = 4'h0;
    I_WDATA = 8'h00;
    repeat (8) @(posedge I_CLK);
    I_RESET_N <= 1'b1;
    rd(ADDR_CTRL, 8'h00, "ctrl reset");
    chk("mv reset", 16'h07D0, O_THRESHOLD_MV);
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_CTRL, 8'(i));
      chk("select", 16'(i), 16'(O_THRESHOLD_SELECT));
      chk("mv", EXP_MV[i], O_THRESHOLD_MV);
    end
    wr(ADDR_CTRL, 8'hFF);
    rd(ADDR_CTRL, 8'h1F, "ctrl upper bits");
    $display("test registers done");

    for (int i = 0; i < 16; i++) begin
      I_LVR_ENABLE <= i[1];
      I_SLEEP      <= i[3];
      wr(ADDR_CTRL, {3'h0, i[0], i[2], 3'h0});
      chk("monitor on", 16'(i[0] & ~i[3]), 16'(O_MONITOR_ON));
      chk("bandgap", 16'((i[0] & ~i[3]) | i[1] | i[2]), 16'(O_BANDGAP_ON));
    end
    I_SLEEP      <= 1'b0;
    I_LVR_ENABLE <= 1'b0;
    $display("test power control done");

    wr(ADDR_CTRL, 8'h13);
    wr(ADDR_IRQ_MASK, 8'h04);
    // settle time after switching on before the flag is trusted
    repeat (4) @(posedge I_CLK);
    I_CMP_BELOW <= 1'b1;
    n = 0;
    while (O_IRQ !== 1'b1 && n < 40) begin
      @(posedge I_CLK);
      #1;
      n++;
    end
    chk("request delay", 16'h0001, 16'(n >= DLY + 3 && n <= DLY + 7));
    rd(ADDR_CTRL, 8'h33, "flag high");
    rd(ADDR_IRQ_STAT, 8'h05, "status rise");
    rd(ADDR_IRQ_STAT, 8'h00, "status cleared");
    chk("irq after clear", 16'h0000, 16'(O_IRQ));
    I_CMP_BELOW <= 1'b0;
    repeat (5) @(posedge I_CLK);
    rd(ADDR_IRQ_REQ, 8'h01, "request sticky");
    rd(ADDR_CTRL, 8'h13, "flag low");
    I_IDLE <= 1'b1;
    @(posedge I_CLK);
    #1;
    chk("wake", 16'h0001, 16'(O_WAKE));
    wr(ADDR_IRQ_REQ, 8'h00);
    chk("wake cleared", 16'h0000, 16'(O_WAKE));
    wr(ADDR_IRQ_REQ, 8'h01);
    rd(ADDR_IRQ_REQ, 8'h01, "request preset");
    wr(ADDR_IRQ_REQ, 8'h00);
    I_IDLE <= 1'b0;
    $display("test request done");

    rd(ADDR_IRQ_STAT, 8'h02, "status fall");
    I_CMP_BELOW <= 1'b1;
    repeat (DLY - 3) @(posedge I_CLK);
    I_CMP_BELOW <= 1'b0;
    repeat (20) @(posedge I_CLK);
    rd(ADDR_IRQ_REQ, 8'h00, "short dip");
    chk("masked irq", 16'h0000, 16'(O_IRQ));
    rd(ADDR_IRQ_STAT, 8'h03, "flag toggled");
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00, "unmapped");
    rd(ADDR_CTRL, 8'h13, "ctrl kept");
    $display("test toggle done");
    results();
  end
endmodule : supply_voltage_monitor_tb_top
`default_nettype wire
